/* File: core/dac_channel_readback_slave.sv */
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "readback_regs.svh"

module dac_channel_readback_slave (
  // Clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // AXI4-Lite write channels
  input  wire logic [7:0]          awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output var readback_pkg::resp_t  bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]          araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output var readback_pkg::resp_t  rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  // Two-wire bus pins
  input  wire logic                scl_i,
  input  wire logic                sda_i,
  output logic                     sda_o,
  output logic                     sda_oe,
  // Address pins
  input  wire logic                addr_pin_hi,
  input  wire logic                addr_pin_lo,
  // Output stage load per channel
  output logic [3:0]               pulldown_1k,
  output logic [3:0]               pulldown_100k
);
  import readback_pkg::*;

  // {channel hit, status hit, channel index}
  function automatic logic [3:0] reg_decode(input logic [7:0] a);
    case (a)
      `OFS_CH0:    reg_decode = 4'h8;
      `OFS_CH1:    reg_decode = 4'h9;
      `OFS_CH2:    reg_decode = 4'ha;
      `OFS_CH3:    reg_decode = 4'hb;
      `OFS_STATUS: reg_decode = 4'h4;
      default:     reg_decode = 4'h0;
    endcase
  endfunction : reg_decode

  function automatic logic [7:0] readback_byte(input logic [1:0] idx, input logic [17:0] w);
    case (idx)
      `BYTE_PWRDN: readback_byte = {w[`CH_MODE_MSB:`CH_MODE_LSB], `PD_BYTE_FILL};
      `BYTE_HIGH:  readback_byte = w[15:8];
      default:     readback_byte = w[7:0];
    endcase
  endfunction : readback_byte

  logic [17:0]  ch_ff [4];
  logic [7:0]   ctrl_ff;
  link_state_t  state_ff;
  logic [3:0]   bit_cnt_ff;
  logic [7:0]   rx_sh_ff;
  logic [7:0]   tx_sh_ff;
  logic [1:0]   idx_ff;
  logic         rd_ff;
  logic         ctrl_phase_ff;
  logic         sda_oe_ff;
  logic         sda_o_ff;
  logic [3:0]   pd1k_ff;
  logic [3:0]   pd100k_ff;
  logic         awready_ff;
  logic         wready_ff;
  logic         aw_hold_ff;
  logic         w_hold_ff;
  logic [7:0]   waddr_ff;
  logic [31:0]  wdata_ff;
  logic [3:0]   wstrb_ff;
  logic         bvalid_ff;
  resp_t        bresp_ff;
  logic         arready_ff;
  logic         rvalid_ff;
  logic [31:0]  rdata_ff;
  resp_t        rresp_ff;

  // Pin sampling
  logic [3:0]   lvl;
  logic [1:0]   rise;
  logic [1:0]   fall;

  line_sampler u_sampler (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     ({addr_pin_hi, addr_pin_lo, scl_i, sda_i}),
    .level   (lvl),
    .rise    (rise),
    .fall    (fall)
  );

  wire        scl_lvl   = lvl[1];
  wire        sda_lvl   = lvl[0];
  wire        scl_rise  = rise[1];
  wire        scl_fall  = fall[1];
  wire        start_det = fall[0] & scl_lvl;
  wire        stop_det  = rise[0] & scl_lvl;
  wire [6:0]  dev_addr  = {`DEV_ADDR_PREFIX, lvl[3], lvl[2]};
  wire        addr_hit  = (rx_sh_ff[7:1] == dev_addr);
  wire [17:0] sel_word  = ch_ff[ctrl_ff[`CTRL_SEL_MSB:`CTRL_SEL_LSB]];
  wire        pd_flag   = ctrl_ff[`CTRL_PD_BIT];
  wire [1:0]  first_idx = pd_flag ? `BYTE_PWRDN : `BYTE_HIGH;
  wire [7:0]  first_byte = readback_byte(first_idx, sel_word);
  wire [7:0]  next_byte  = readback_byte(idx_ff, sel_word);
  wire        rx_done   = scl_fall & (bit_cnt_ff == `BITS_PER_BYTE);
  wire        active    = (state_ff == ST_TX) | (state_ff == ST_TX_ACK) | (state_ff == ST_TX_NEXT);

  // Link state machine; stop and start win over any byte in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff      <= ST_IDLE;
      bit_cnt_ff    <= 4'h0;
      rx_sh_ff      <= 8'h00;
      tx_sh_ff      <= 8'h00;
      idx_ff        <= `BYTE_HIGH;
      rd_ff         <= 1'b0;
      ctrl_phase_ff <= 1'b0;
      ctrl_ff       <= `CTRL_RESET;
      sda_oe_ff     <= 1'b0;
    end else if (stop_det) begin
      state_ff  <= ST_IDLE;
      sda_oe_ff <= 1'b0;
    end else if (start_det) begin
      state_ff      <= ST_RX;
      bit_cnt_ff    <= 4'h0;
      ctrl_phase_ff <= 1'b0;
      sda_oe_ff     <= 1'b0;
    end else begin
      case (state_ff)
        ST_RX: begin
          if (scl_rise) begin
            rx_sh_ff   <= {rx_sh_ff[6:0], sda_lvl};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end else if (rx_done && ctrl_phase_ff) begin
            ctrl_ff   <= rx_sh_ff;
            state_ff  <= ST_ACK;
            sda_oe_ff <= 1'b1;
          end else if (rx_done && addr_hit) begin
            rd_ff     <= rx_sh_ff[0];
            state_ff  <= ST_ACK;
            sda_oe_ff <= 1'b1;
          end else if (rx_done) begin
            state_ff <= ST_WAIT;
          end
        end
        ST_ACK: begin
          if (scl_fall && rd_ff) begin
            idx_ff     <= first_idx;
            tx_sh_ff   <= first_byte;
            sda_oe_ff  <= ~first_byte[7];
            bit_cnt_ff <= 4'h0;
            state_ff   <= ST_TX;
          end else if (scl_fall && !ctrl_phase_ff) begin
            ctrl_phase_ff <= 1'b1;
            bit_cnt_ff    <= 4'h0;
            sda_oe_ff     <= 1'b0;
            state_ff      <= ST_RX;
          end else if (scl_fall) begin
            // Data writes are not handled here; the bytes go unacknowledged
            sda_oe_ff <= 1'b0;
            state_ff  <= ST_WAIT;
          end
        end
        ST_TX: begin
          if (scl_fall && bit_cnt_ff == `TX_LAST_BIT) begin
            sda_oe_ff <= 1'b0;
            state_ff  <= ST_TX_ACK;
          end else if (scl_fall) begin
            tx_sh_ff   <= {tx_sh_ff[6:0], 1'b0};
            sda_oe_ff  <= ~tx_sh_ff[6];
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
        end
        ST_TX_ACK: begin
          // The low byte ends the read even if the master acknowledges it
          if (scl_rise && !sda_lvl && idx_ff != `BYTE_LOW) begin
            idx_ff   <= idx_ff + 2'h1;
            state_ff <= ST_TX_NEXT;
          end else if (scl_rise) begin
            state_ff <= ST_WAIT;
          end
        end
        ST_TX_NEXT: begin
          if (scl_fall) begin
            tx_sh_ff   <= next_byte;
            sda_oe_ff  <= ~next_byte[7];
            bit_cnt_ff <= 4'h0;
            state_ff   <= ST_TX;
          end
        end
        default: begin
          sda_oe_ff <= 1'b0;
        end
      endcase
    end
  end

  // AXI4-Lite write path; address and data may arrive in either order
  wire [3:0] wdec      = reg_decode(waddr_ff);
  wire       aw_take   = awvalid & awready_ff;
  wire       w_take    = wvalid & wready_ff;
  wire       wr_commit = aw_hold_ff & w_hold_ff & ~bvalid_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      waddr_ff   <= 8'h00;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end else begin
      aw_hold_ff <= aw_take | (aw_hold_ff & ~wr_commit);
      w_hold_ff  <= w_take | (w_hold_ff & ~wr_commit);
      awready_ff <= ~aw_take & ~aw_hold_ff & ~bvalid_ff;
      wready_ff  <= ~w_take & ~w_hold_ff & ~bvalid_ff;
      if (aw_take) waddr_ff <= awaddr;
      if (w_take) begin
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
      end
      if (wr_commit) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= (wdec[3] | wdec[2]) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Channel words steer what the link sends back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) ch_ff[i] <= `CH_RESET;
    end else if (wr_commit && wdec[3]) begin
      if (wstrb_ff[0]) ch_ff[wdec[1:0]][7:0] <= wdata_ff[7:0];
      if (wstrb_ff[1]) ch_ff[wdec[1:0]][15:8] <= wdata_ff[15:8];
      if (wstrb_ff[2]) ch_ff[wdec[1:0]][17:16] <= wdata_ff[17:16];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pd1k_ff   <= 4'h0;
      pd100k_ff <= 4'h0;
      sda_o_ff  <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        pd1k_ff[i]   <= (ch_ff[i][17:16] == PWRDN_1K);
        pd100k_ff[i] <= (ch_ff[i][17:16] == PWRDN_100K);
      end
      sda_o_ff <= 1'b0;
    end
  end

  // AXI4-Lite read path
  wire [3:0]  rdec    = reg_decode(araddr);
  wire        ar_take = arvalid & arready_ff;
  wire [31:0] status_word = {21'h000000, lvl[3], lvl[2], active, ctrl_ff};
  wire [31:0] rd_word = rdec[3] ? {14'h0000, ch_ff[rdec[1:0]]} :
                        rdec[2] ? status_word : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= RESP_OKAY;
    end else begin
      arready_ff <= ~ar_take & ~rvalid_ff;
      if (ar_take) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rd_word;
        rresp_ff  <= (rdec[3] | rdec[2]) ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign awready = awready_ff;
  assign wready  = wready_ff;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;
  assign arready = arready_ff;
  assign rvalid  = rvalid_ff;
  assign rdata   = rdata_ff;
  assign rresp   = rresp_ff;
  assign sda_o   = sda_o_ff;
  assign sda_oe  = sda_oe_ff;
  assign pulldown_1k   = pd1k_ff;
  assign pulldown_100k = pd100k_ff;

  AST_ADDR_ACK: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_ff == ST_RX && rx_done && !ctrl_phase_ff && addr_hit && !start_det && !stop_det)
    |=> sda_oe_ff && state_ff == ST_ACK) else $error("address byte not acknowledged");
  AST_CTRL_ACK: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_ff == ST_RX && rx_done && ctrl_phase_ff && !start_det && !stop_det)
    |=> sda_oe_ff && ctrl_ff == $past(rx_sh_ff)) else $error("control byte not taken");
  AST_TWO_BYTES: assert property (@(posedge aclk) disable iff (!aresetn)
    (active && !pd_flag) |-> idx_ff != `BYTE_PWRDN) else $error("power-down byte sent");
  AST_FIRST_PD: assert property (@(posedge aclk) disable iff (!aresetn)
    ($rose(state_ff == ST_TX) && $past(state_ff) == ST_ACK && pd_flag)
    |-> idx_ff == `BYTE_PWRDN) else $error("three-byte read did not start with mode byte");
  AST_PD_BYTE: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_ff == ST_TX && idx_ff == `BYTE_PWRDN && bit_cnt_ff == 4'h0)
    |-> tx_sh_ff == {sel_word[17:16], 6'h3f}) else $error("bad power-down byte");
  AST_HIGH_BYTE: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_ff == ST_TX && idx_ff == `BYTE_HIGH && bit_cnt_ff == 4'h0)
    |-> tx_sh_ff == sel_word[15:8]) else $error("bad high byte");
  AST_LOW_BYTE: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_ff == ST_TX && idx_ff == `BYTE_LOW && bit_cnt_ff == 4'h0)
    |-> tx_sh_ff == sel_word[7:0]) else $error("bad low byte");
  AST_LOW_LAST: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_ff == ST_TX_ACK && idx_ff == `BYTE_LOW && scl_rise && !start_det && !stop_det)
    |=> state_ff == ST_WAIT && !sda_oe_ff) else $error("read went past low byte");
  AST_TX_DRIVE: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_ff == ST_TX && $past(state_ff) == ST_TX) |-> sda_oe_ff == ~tx_sh_ff[7])
    else $error("data line does not follow shift bit");
  AST_RESET_ZERO: assert property (@(posedge aclk)
    !aresetn |=> (ch_ff[0] == 18'h0 && ch_ff[1] == 18'h0 && ch_ff[2] == 18'h0 &&
                  ch_ff[3] == 18'h0)) else $error("channel not cleared");

endmodule : dac_channel_readback_slave

`default_nettype wire

/* File: core/line_sampler.sv */
`timescale 1ns/1ps
`default_nettype none

module line_sampler (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Raw pins: address straps in [3:2], clock line [1], data line [0]
  input  wire logic [3:0] din,
  // Filtered levels of all four pins and edge pulses of the two bus lines
  output logic      [3:0] level,
  output logic      [1:0] rise,
  output logic      [1:0] fall
);

  logic [3:0] s1_ff;
  logic [3:0] s2_ff;
  logic [3:0] s3_ff;
  logic [3:0] level_ff;
  wire  [3:0] nxt_level = (s2_ff & s3_ff) | (level_ff & (s2_ff | s3_ff));

  // Idle bus lines are high, so reset to high avoids a false start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_ff    <= 4'hf;
      s2_ff    <= 4'hf;
      s3_ff    <= 4'hf;
      level_ff <= 4'hf;
    end else begin
      s1_ff    <= din;
      s2_ff    <= s1_ff;
      s3_ff    <= s2_ff;
      level_ff <= nxt_level;
    end
  end

  assign level = level_ff;
  // Edges come from the next level, a cycle ahead of a registered pulse, so a reply
  // still lands inside a short low phase; a line seen changing with the clock line
  // in the same cycle is judged against the old clock level, so it makes a start or stop only when the clock line falls
  assign rise  = nxt_level[1:0] & ~level_ff[1:0];
  assign fall  = ~nxt_level[1:0] & level_ff[1:0];

endmodule : line_sampler

`default_nettype wire

/* File: core/readback_pkg.sv */
package readback_pkg;

  typedef enum logic [1:0] {
    RESP_OKAY   = 2'h0,
    RESP_SLVERR = 2'h2
  } resp_t;

  typedef enum logic [1:0] {
    PWRDN_HIZ    = 2'h0,
    PWRDN_1K     = 2'h1,
    PWRDN_100K   = 2'h2,
    PWRDN_HIZ_2  = 2'h3
  } pwrdn_mode_t;

  typedef enum {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_TX_ACK,
    ST_TX_NEXT,
    ST_WAIT
  } link_state_t;

endpackage : readback_pkg

/* File: core/readback_regs.svh */
`ifndef READBACK_REGS_SVH
`define READBACK_REGS_SVH

// Register byte offsets on the AXI4-Lite port
`define OFS_CH0          8'h00
`define OFS_CH1          8'h04
`define OFS_CH2          8'h08
`define OFS_CH3          8'h0c
`define OFS_STATUS       8'h10

// Channel word layout
`define CH_MODE_MSB      17
`define CH_MODE_LSB      16
`define CH_RESET         18'h00000

// Control byte layout
`define CTRL_PD_BIT      0
`define CTRL_SEL_LSB     1
`define CTRL_SEL_MSB     2
`define CTRL_RESET       8'h00

// Bus address and read-back bytes
`define DEV_ADDR_PREFIX  5'h13
`define PD_BYTE_FILL     6'h3f
`define BYTE_PWRDN       2'h0
`define BYTE_HIGH        2'h1
`define BYTE_LOW         2'h2
`define BITS_PER_BYTE    4'h8
`define TX_LAST_BIT      4'h7

`endif

/* File: sim/dac_channel_readback_slave_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "readback_regs.svh"

module dac_channel_readback_slave_tb_top;
  import readback_pkg::*;

  logic        aclk, aresetn;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, pulldown_1k, pulldown_100k;
  logic        awready, wready, bvalid, arready, rvalid;
  resp_t       bresp, rresp;
  logic        scl, sda_pull, sda_o, sda_oe, addr_pin_hi, addr_pin_lo;
  wire         sda_line;
  int          num_errors, checks_done;

  localparam logic [6:0] dev_addr = {5'h13, 2'h2};

  // Open-drain line with pull-up: low while either party pulls
  assign sda_line = ~(sda_pull | (sda_oe & ~sda_o));

  dac_channel_readback_slave u_dac_channel_readback_slave (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .scl_i(scl), .sda_i(sda_line), .sda_o, .sda_oe, .addr_pin_hi, .addr_pin_lo,
    .pulldown_1k, .pulldown_100k
  );

  link_master u_link_master (.scl, .sda_pull, .sda(sda_line));

  always #10 aclk = ~aclk;

  task automatic complete_run();
    if (num_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  task automatic check_val(input logic [31:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_val

  task automatic check_bit(input logic got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : check_bit

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output resp_t r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output resp_t r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_read

  task automatic readback_case(input logic [1:0] ch, input logic pd, input logic [17:0] w);
    logic       a;
    logic [7:0] b;
    u_link_master.start_cond();
    u_link_master.send_byte({dev_addr, 1'b0}, a);
    check_bit(a, 1'b0, "write address ack");
    u_link_master.send_byte({5'h00, ch, pd}, a);
    check_bit(a, 1'b0, "control ack");
    u_link_master.start_cond();
    u_link_master.send_byte({dev_addr, 1'b1}, a);
    check_bit(a, 1'b0, "read address ack");
    if (pd) begin
      u_link_master.recv_byte(1'b1, b, a);
      check_val(b, {w[17:16], 6'h3f}, "power-down byte");
    end
    u_link_master.recv_byte(1'b1, b, a);
    check_val(b, w[15:8], "high byte");
    u_link_master.recv_byte(1'b0, b, a);
    check_val(b, w[7:0], "low byte");
    check_bit(a, 1'b1, "line released after low byte");
    u_link_master.stop_cond();
    check_bit(sda_oe, 1'b0, "no drive after stop");
  endtask : readback_case

  task automatic reset_values_case();
    logic [31:0] d;
    resp_t       r;
    for (int i = 0; i < 4; i++) begin
      axi_read(8'(i * 4), d, r);
      check_val(d, 32'h0, "channel word at reset");
    end
    readback_case(2'h2, 1'b1, 18'h0);
  endtask : reset_values_case

  // Channels are read in descending order so a stuck select cannot pass
  task automatic channels_case();
    logic [17:0] w [4];
    resp_t       r;
    for (int i = 0; i < 4; i++) begin
      w[i] = {2'(i), 16'h8c31 + 16'(i) * 16'h1111};
      axi_write(8'(i * 4), {14'h0, w[i]}, r);
      check_val(r, RESP_OKAY, "channel write response");
    end
    for (int i = 0; i < 8; i++) begin
      readback_case(2'h3 ^ 2'(i / 2), 1'(i % 2), w[3 - i / 2]);
    end
    check_val(pulldown_1k, 4'h2, "1k load decode");
    check_val(pulldown_100k, 4'h4, "100k load decode");
  endtask : channels_case

  task automatic wrong_addr_case();
    logic a;
    for (int i = 0; i < 2; i++) begin
      u_link_master.start_cond();
      u_link_master.send_byte(i ? {5'h12, 2'h2, 1'b0} : {5'h13, 2'h1, 1'b0}, a);
      check_bit(a, 1'b1, "foreign address ignored");
      u_link_master.stop_cond();
    end
  endtask : wrong_addr_case

  task automatic regmap_case();
    logic [31:0] d;
    resp_t       r;
    axi_read(8'h14, d, r);
    check_val(r, RESP_SLVERR, "unmapped read response");
    check_val(d, 32'h0, "unmapped read data");
    axi_write(8'h14, 32'hffff_ffff, r);
    check_val(r, RESP_SLVERR, "unmapped write response");
    axi_read(`OFS_STATUS, d, r);
    check_val(d, 32'h0000_0401, "status after last read-back");
  endtask : regmap_case

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hf;
    addr_pin_hi = 1'b1;
    addr_pin_lo = 1'b0;
    num_errors = 0;
    checks_done = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    reset_values_case();
    channels_case();
    wrong_addr_case();
    regmap_case();
    complete_run();
  end

  // About seven times the expected length of the whole run
  initial begin
    repeat (30000) @(posedge aclk);
    num_errors++;
    complete_run();
  end
endmodule : dac_channel_readback_slave_tb_top

`default_nettype wire

/* File: sim/link_master.sv */
`timescale 1ns/1ps
`default_nettype none

module link_master (
  // Bus lines
  output var logic scl,
  output var logic sda_pull,
  input  wire logic sda
);
  // Clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Low phase is longer than high: the device's pin filter needs four cycles
  // after a fall before its next bit is on the line, and that must precede the rise
  task automatic bit_xfer(input logic b, output logic s);
    #40 sda_pull <= ~b;
    #60 scl <= 1'b1;
    #58 s = sda;
    #2 scl <= 1'b0;
  endtask : bit_xfer

  // Long lead-in lets the device drop a late acknowledge before the line rises
  task automatic start_cond();
    #60 sda_pull <= 1'b0;
    #60 scl <= 1'b1;
    #80 sda_pull <= 1'b1;
    #80 scl <= 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    #40 sda_pull <= 1'b1;
    #40 scl <= 1'b1;
    #80 sda_pull <= 1'b0;
    #80;
  endtask : stop_cond

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(b[i], s);
    end
    bit_xfer(1'b1, ack);
  endtask : send_byte

  task automatic recv_byte(input logic ack, output logic [7:0] b, output logic s);
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, b[i]);
    end
    bit_xfer(~ack, s);
  endtask : recv_byte
endmodule : link_master

`default_nettype wire
